// ==== hw/blt_pkg.sv ====
// Purpose: Shared constants and types for the block-transfer sequencer
// Assumes: 16-bit frame-buffer words, 24-bit byte addresses
// Notes:   Opcode encodings match the instruction word fields
package blt_pkg;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;

  // Operation field and i field encodings
  localparam logic [3:0] OP_AND      = 4'h a;
  localparam logic [3:0] OP_OR       = 4'h 6;
  localparam logic [3:0] OP_XOR      = 4'h e;
  localparam logic [3:0] OP_FAST_OR  = 4'h c;
  localparam logic [3:0] OP_COPY     = 4'h 4;
  localparam logic [1:0] I_AND       = 2'h 3;
  localparam logic [1:0] I_OTHER     = 2'h 1;

  // Instruction word field positions
  localparam int POS_DEC   = 15;
  localparam int POS_INV   = 14;
  localparam int POS_AND_X = 9;
  localparam int POS_OP    = 10;
  localparam int POS_I     = 8;

  // Step of one word in bytes
  localparam logic [23:0] WORD_STEP = 24'h00_0002;

  // Reset values
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [23:0] ADDR_ZERO = 24'h00_0000;

  typedef enum logic [2:0] {
    CMD_BB,
    CMD_WORD_OR,
    CMD_EXT,
    CMD_NONE
  } cmd_kind_t;

  // Setup values taken from the general registers and stack top
  typedef struct packed {
    logic [23:0] src_base;
    logic [23:0] dst_base;
    logic [3:0]  shift;
    logic [15:0] height;
    logic [15:0] mask_first;
    logic [15:0] mask_last;
    logic [23:0] src_warp;
    logic [23:0] dst_warp;
    logic [15:0] width;
    logic [23:0] h_step;
  } setup_t;

  // Memory request word
  typedef struct packed {
    logic        write;
    logic [23:0] addr;
    logic [15:0] data;
    logic [1:0]  kind;
  } mem_req_t;

  localparam logic [1:0] KIND_SRC_RD = 2'h 0;
  localparam logic [1:0] KIND_DST_RD = 2'h 1;
  localparam logic [1:0] KIND_DST_WR = 2'h 2;

endpackage

// ==== hw/req_buffer.sv ====
// Purpose: Two-entry skid buffer for memory requests
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Full when two words held; ready reflects free space
`timescale 1ns/1ns
module req_buffer #(
  parameter int WIDTH = 42
) (
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  logic [WIDTH-1:0] slot_r [2];
  logic [1:0]       count_r;
  logic             rd_ptr_r;
  logic             wr_ptr_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_r != 2'h2);
  assign out_valid_o = (count_r != 2'h0);
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_data_o  = slot_r[rd_ptr_r];

  // Occupancy and pointers
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_r  <= 2'h0;
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
    end else begin
      count_r  <= count_r + {1'b0, push} - {1'b0, pop};
      if (push) wr_ptr_r <= ~wr_ptr_r;
      if (pop)  rd_ptr_r <= ~rd_ptr_r;
    end
  end

  // Storage
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      slot_r[0] <= '0;
      slot_r[1] <= '0;
    end else if (push) begin
      slot_r[wr_ptr_r] <= in_data_i;
    end
  end

endmodule

// ==== hw/bit_aligned_block_transfer.sv ====
// Purpose: Sequencer for bit-aligned block transfers on a frame buffer
// Assumes: Setup values are stable from start until done
// Notes:   Requests go out through a two-entry buffer; read data returns
//          on rd_valid_i in request order
`timescale 1ns/1ns
module bit_aligned_block_transfer (
  input  wire logic                   clock_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   start_i,
  input  wire logic [23:0]            instr_i,
  input  wire blt_pkg::setup_t        setup_i,
  input  wire logic                   low_flag_i,
  output logic                        busy_o,
  output logic                        done_o,
  output logic                        bad_opts_o,
  output logic [23:0]                 src_ptr_o,
  output logic [23:0]                 dst_ptr_o,
  output logic                        req_valid_o,
  input  wire logic                   req_ready_i,
  output blt_pkg::mem_req_t           req_o,
  input  wire logic                   rd_valid_i,
  input  wire logic [15:0]            rd_data_i
);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LINE,
    ST_SRC_RD,
    ST_DST_RD,
    ST_WAIT,
    ST_WRITE,
    ST_DONE
  } state_t;

  state_t            state_r;
  blt_pkg::cmd_kind_t kind_r;
  logic [3:0]        op_r;
  logic              dec_r;
  logic              inv_r;
  logic              prime_r;
  logic [23:0]       src_r;
  logic [23:0]       dst_r;
  logic [23:0]       line_src_r;
  logic [23:0]       line_dst_r;
  logic [15:0]       width_left_r;
  logic [15:0]       lines_left_r;
  logic [15:0]       src_word_r;
  logic [15:0]       prev_word_r;
  logic [15:0]       dst_word_r;
  logic [1:0]        pend_r;
  logic              first_r;
  logic              got_src_r;
  logic              got_dst_r;
  logic [31:0]       wide_shift;
  logic [31:0]       word_wide;
  logic [15:0]       aligned;
  logic [15:0]       srcv;
  logic [15:0]       combined;
  logic [15:0]       mask;
  logic [15:0]       result;
  logic [23:0]       h_step;
  logic              last_word;
  logic              buf_ready;
  logic              push;
  blt_pkg::mem_req_t push_req;
  logic [3:0]        dec_op;
  logic [1:0]        dec_i;
  logic              dec_x;
  logic              dec_da;
  logic              dec_inv;
  logic              bb_ok;
  logic              opts_bad;
  logic              prime_now;

  // Instruction word decode
  assign dec_op  = instr_i[blt_pkg::POS_OP +: 4];
  assign dec_i   = instr_i[blt_pkg::POS_I +: 2];
  assign dec_x   = instr_i[blt_pkg::POS_AND_X];
  assign dec_da  = instr_i[blt_pkg::POS_DEC];
  assign dec_inv = instr_i[blt_pkg::POS_INV];
  always_comb begin
    bb_ok = 1'b0;
    case (dec_op)
      blt_pkg::OP_AND:     bb_ok = (dec_i == blt_pkg::I_AND) && dec_x;
      blt_pkg::OP_OR,
      blt_pkg::OP_XOR,
      blt_pkg::OP_FAST_OR,
      blt_pkg::OP_COPY:    bb_ok = (dec_i == blt_pkg::I_OTHER) && !dec_x;
      default:             bb_ok = 1'b0;
    endcase
  end
  // Fast OR refuses both options
  assign opts_bad = (dec_op == blt_pkg::OP_FAST_OR) &&
                    (dec_da || dec_inv);

  // Direction step: address option for internal, step sign for external
  always_comb begin
    if (kind_r == blt_pkg::CMD_EXT) begin
      h_step = setup_i.h_step;
    end else if (dec_r) begin
      h_step = 24'(-blt_pkg::WORD_STEP);
    end else begin
      h_step = blt_pkg::WORD_STEP;
    end
  end

  assign last_word = (width_left_r == 16'h0001);

  // Priming read: first source read of an external line
  assign prime_now = (state_r == ST_SRC_RD) && buf_ready &&
                     (kind_r == blt_pkg::CMD_EXT) && prime_r && first_r &&
                     !got_src_r && (pend_r == 2'h0);

  // Align source: bring in bits from previous word, bit 0 first pixel
  assign wide_shift = {src_word_r, prev_word_r} << setup_i.shift;
  // Word OR spans a double word: low half first, high half second
  assign word_wide  = {16'h0000, src_word_r} << setup_i.shift;
  assign aligned    = (kind_r == blt_pkg::CMD_WORD_OR) ?
                      (first_r ? word_wide[15:0] : word_wide[31:16]) :
                      wide_shift[31:16];
  assign srcv = inv_r ? ~aligned : aligned;

  // Logic function
  always_comb begin
    case (op_r)
      blt_pkg::OP_AND:     combined = srcv & dst_word_r;
      blt_pkg::OP_OR,
      blt_pkg::OP_FAST_OR: combined = srcv | dst_word_r;
      blt_pkg::OP_XOR:     combined = srcv ^ dst_word_r;
      blt_pkg::OP_COPY:    combined = srcv;
      default:             combined = dst_word_r;
    endcase
  end

  // Edge masks: first word and last word of each bit-aligned block transfer line only, destination relative
  always_comb begin
    mask = 16'h ffff;
    if (kind_r == blt_pkg::CMD_BB) begin
      if (first_r) mask = mask & setup_i.mask_first;
      if (last_word) mask = mask & setup_i.mask_last;
    end
  end
  assign result = (combined & mask) | (dst_word_r & ~mask);

  // Request buffer push
  always_comb begin
    push     = 1'b0;
    push_req = '0;
    case (state_r)
      ST_SRC_RD: begin
        push          = 1'b1;
        push_req.addr = src_r;
        push_req.kind = blt_pkg::KIND_SRC_RD;
      end
      ST_DST_RD: begin
        push          = 1'b1;
        push_req.addr = dst_r;
        push_req.kind = blt_pkg::KIND_DST_RD;
      end
      ST_WRITE: begin
        push           = 1'b1;
        push_req.write = 1'b1;
        push_req.addr  = dst_r;
        push_req.data  = (kind_r == blt_pkg::CMD_EXT) ? src_word_r : result;
        push_req.kind  = blt_pkg::KIND_DST_WR;
      end
      default: push = 1'b0;
    endcase
  end

  req_buffer #(
    .WIDTH ($bits(blt_pkg::mem_req_t))
  ) u_buf (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .in_valid_i  (push),
    .in_ready_o  (buf_ready),
    .in_data_i   (push_req),
    .out_valid_o (req_valid_o),
    .out_ready_i (req_ready_i),
    .out_data_o  (req_o)
  );

  // Read data capture; each read returns in order
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_word_r  <= blt_pkg::WORD_ZERO;
      prev_word_r <= blt_pkg::WORD_ZERO;
      dst_word_r  <= blt_pkg::WORD_ZERO;
      got_src_r   <= 1'b0;
      got_dst_r   <= 1'b0;
    end else begin
      if (state_r == ST_LINE) begin
        prev_word_r <= blt_pkg::WORD_ZERO;
        got_src_r   <= 1'b0;
        got_dst_r   <= 1'b0;
      end else if (state_r == ST_WRITE && buf_ready) begin
        got_src_r <= 1'b0;
        got_dst_r <= 1'b0;
        prev_word_r <= src_word_r;
      end
      if (rd_valid_i && pend_r != 2'h1) begin
        prev_word_r <= src_word_r;
        src_word_r  <= rd_data_i;
        got_src_r   <= 1'b1;
      end else if (rd_valid_i) begin
        dst_word_r <= rd_data_i;
        got_dst_r  <= 1'b1;
      end
    end
  end

  // Which read comes back next: 1 destination, else source; 2 after prime
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_r <= 2'h0;
    end else if (rd_valid_i) begin
      pend_r <= (pend_r == 2'h0) ? 2'h1 : 2'h0;
    end else if (prime_now) begin
      pend_r <= 2'h2;
    end else if (state_r == ST_LINE) begin
      pend_r <= 2'h0;
    end
  end

  // Sequencer: nested scan-line and word loops
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r      <= ST_IDLE;
      kind_r       <= blt_pkg::CMD_NONE;
      op_r         <= 4'h0;
      dec_r        <= 1'b0;
      inv_r        <= 1'b0;
      prime_r      <= 1'b0;
      first_r      <= 1'b0;
      src_r        <= blt_pkg::ADDR_ZERO;
      dst_r        <= blt_pkg::ADDR_ZERO;
      line_src_r   <= blt_pkg::ADDR_ZERO;
      line_dst_r   <= blt_pkg::ADDR_ZERO;
      width_left_r <= 16'h0000;
      lines_left_r <= 16'h0000;
      bad_opts_o   <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (start_i) begin
            bad_opts_o <= 1'b0;
            op_r       <= dec_op;
            dec_r      <= dec_da;
            inv_r      <= dec_inv;
            src_r      <= setup_i.src_base;
            dst_r      <= setup_i.dst_base;
            line_src_r <= setup_i.src_base;
            line_dst_r <= setup_i.dst_base;
            lines_left_r <= setup_i.height;
            if (instr_i[7:0] == 8'h 0e && instr_i[15:8] == 8'h 21 &&
                instr_i[23:16] == 8'h 00) begin
              kind_r       <= blt_pkg::CMD_WORD_OR;
              op_r         <= blt_pkg::OP_OR;
              width_left_r <= 16'h0002;
              first_r      <= 1'b1;
              lines_left_r <= 16'h0001;
              state_r      <= ST_SRC_RD;
            end else if (instr_i[15:8] == 8'h 17 &&
                         instr_i[7:0] == 8'h 0e) begin
              kind_r       <= blt_pkg::CMD_EXT;
              inv_r        <= 1'b0;
              dec_r        <= 1'b0;
              prime_r      <= !low_flag_i;
              state_r      <= ST_LINE;
            end else if (bb_ok && !opts_bad) begin
              kind_r  <= blt_pkg::CMD_BB;
              state_r <= ST_LINE;
            end else begin
              bad_opts_o <= 1'b1;
              state_r    <= ST_DONE;
            end
          end
        end
        ST_LINE: begin
          // Line start: reload width, extra priming read where asked
          first_r <= 1'b1;
          src_r   <= line_src_r;
          dst_r   <= line_dst_r;
          width_left_r <= (kind_r == blt_pkg::CMD_EXT) ?
                          (setup_i.width >> 1) : setup_i.width;
          if (lines_left_r == 16'h0000) begin
            state_r <= ST_DONE;
          end else begin
            state_r <= ST_SRC_RD;
          end
        end
        ST_SRC_RD: begin
          if (buf_ready) begin
            // Word OR reads its one source word twice, then steps
            if (kind_r != blt_pkg::CMD_WORD_OR || !first_r) begin
              src_r <= src_r + h_step;
            end
            if (prime_now) begin
              state_r <= ST_SRC_RD;
              first_r <= 1'b0;
            end else begin
              state_r <= ST_DST_RD;
            end
          end
        end
        ST_DST_RD: begin
          if (buf_ready) state_r <= ST_WAIT;
        end
        ST_WAIT: begin
          if (got_src_r && got_dst_r) state_r <= ST_WRITE;
        end
        ST_WRITE: begin
          if (buf_ready) begin
            first_r      <= 1'b0;
            dst_r        <= dst_r + h_step;
            width_left_r <= width_left_r - 16'h0001;
            if (last_word) begin
              // Warp sign sets vertical direction; odd src_warp is fine, odd dst_warp gives odd write addresses
              line_src_r   <= src_r - h_step + setup_i.src_warp;
              line_dst_r   <= dst_r + setup_i.dst_warp;
              lines_left_r <= lines_left_r - 16'h0001;
              state_r      <= ST_LINE;
              if (kind_r == blt_pkg::CMD_WORD_OR) begin
                line_src_r <= src_r;
                line_dst_r <= dst_r;
              end
            end else begin
              state_r <= ST_SRC_RD;
            end
          end
        end
        ST_DONE: begin
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Final pointers: last address plus warp; Word OR leaves both at base plus one word step
  assign src_ptr_o = line_src_r;
  assign dst_ptr_o = line_dst_r;
  assign busy_o    = (state_r != ST_IDLE);
  assign done_o    = (state_r == ST_DONE);

endmodule

// ==== test/blt_assertions.sv ====
// Purpose: Port assertions for the block-transfer sequencer
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to the sequencer module below the checker
`timescale 1ns/1ns
module blt_assertions (
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  input  wire logic              start_i,
  input  wire logic              busy_o,
  input  wire logic              done_o,
  input  wire logic              bad_opts_o,
  input  wire logic              req_valid_o,
  input  wire logic              req_ready_i,
  input  wire blt_pkg::mem_req_t req_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);

  wire logic acc_w = req_valid_o && req_ready_i;
  wire logic rd_w  = acc_w && req_o.kind == blt_pkg::KIND_DST_RD;
  wire logic wr_w  = acc_w && req_o.kind == blt_pkg::KIND_DST_WR;
  logic [7:0] open_rd_r;

  // Destination reads not yet answered by a write
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      open_rd_r <= 8'h00;
    end else begin
      open_rd_r <= open_rd_r + {7'h00, rd_w} - {7'h00, wr_w};
    end
  end

  sequence start_taken;
    start_i && !busy_o;
  endsequence
  sequence held_req;
    req_valid_o && !req_ready_i;
  endsequence

  a_start_busy: assert property (start_taken |=> busy_o)
    else $error("busy did not follow an accepted start");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(start_i))
    else $error("busy rose without a start");
  a_done_pulse: assert property (done_o |=> !done_o)
    else $error("done lasted more than one cycle");
  a_done_busy: assert property (done_o |-> busy_o ##1 !busy_o)
    else $error("done without a running transfer");
  a_req_stable: assert property (held_req |=> req_valid_o && $stable(req_o))
    else $error("stalled request changed or dropped");
  a_kind_write: assert property (req_valid_o |->
      req_o.write == (req_o.kind == blt_pkg::KIND_DST_WR))
    else $error("write flag disagrees with request kind");
  a_write_even: assert property (req_valid_o && req_o.write |-> !req_o.addr[0])
    else $error("write to an odd byte address");
  a_write_paired: assert property (wr_w |-> open_rd_r != 8'h00)
    else $error("write without a preceding destination read");
  a_bad_hold: assert property (bad_opts_o && !start_i |=> bad_opts_o)
    else $error("option error flag cleared without a start");
endmodule

bind bit_aligned_block_transfer blt_assertions chk_u (
  .clock_i    (clock_i),
  .reset_n_i  (reset_n_i),
  .start_i    (start_i),
  .busy_o     (busy_o),
  .done_o     (done_o),
  .bad_opts_o (bad_opts_o),
  .req_valid_o(req_valid_o),
  .req_ready_i(req_ready_i),
  .req_o      (req_o)
);

// ==== test/blt_mem_model.sv ====
// Purpose: Frame-buffer memory and external unit on the request stream
// Assumes: Reads are answered in request order
// Notes:   Unwritten words hold an address-derived pattern
`timescale 1ns/1ns
module blt_mem_model (
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  input  wire logic              stall_i,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire blt_pkg::mem_req_t req_i,
  output logic                   rd_valid_o,
  output logic      [15:0]       rd_data_o
);
  logic [15:0] mem [int];
  logic [15:0] rq [$];
  int          cnt [3];
  int          seed = 17;

  // Whole 16-bit word at a byte address
  function automatic logic [15:0] peek(input logic [23:0] a);
    int k;
    k = int'(a[23:1]);
    if (mem.exists(k)) begin
      return mem[k];
    end
    return k[15:0] ^ 16'ha5c3 ^ {k[7:0], k[15:8]};
  endfunction

  // Takes requests, stores writes, answers reads, stalls at random
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      req_ready_o <= 1'b0;
      rd_valid_o  <= 1'b0;
      rd_data_o   <= 16'hffff;
      rq.delete();
    end else begin
      if (req_valid_i && req_ready_o) begin
        cnt[req_i.kind]++;
        if (req_i.write) begin
          mem[int'(req_i.addr[23:1])] = req_i.data;
        end else begin
          rq.push_back(peek(req_i.addr));
        end
      end
      req_ready_o <= !stall_i || $random(seed) % 2 == 0;
      if (rq.size() > 0 && (!stall_i || $random(seed) % 2 == 0)) begin
        rd_valid_o <= 1'b1;
        rd_data_o  <= rq.pop_front();
      end else begin
        rd_valid_o <= 1'b0;
        rd_data_o  <= ~rd_data_o; // Stale data never stays put
      end
    end
  end
endmodule

// ==== test/bit_aligned_block_transfer_bench.sv ====
// Purpose: Self-checking bench for the block-transfer sequencer
// Assumes: Memory model answers every request
// Notes:   Source and destination regions never overlap
`timescale 1ns/1ns
module bit_aligned_block_transfer_bench;
  logic              clock_i = 1'b0;
  logic              reset_n_i = 1'b0;
  logic              start_i = 1'b0;
  logic [23:0]       instr_i = 24'h00_0000;
  blt_pkg::setup_t   setup_i = '0;
  logic              low_flag_i = 1'b0;
  logic              stall = 1'b0;
  logic              busy_o, done_o, bad_opts_o, req_valid_o;
  logic              req_ready_i, rd_valid_i;
  logic [23:0]       src_ptr_o, dst_ptr_o;
  logic [15:0]       rd_data_i;
  blt_pkg::mem_req_t req_o;
  int                mismatches = 0;
  int                checks = 0;
  int                seed = 63667;
  int                c0 [3];
  localparam logic [3:0] OPS [5] = '{blt_pkg::OP_AND, blt_pkg::OP_OR,
    blt_pkg::OP_XOR, blt_pkg::OP_FAST_OR, blt_pkg::OP_COPY};

  always #20 clock_i = ~clock_i;

  bit_aligned_block_transfer dut_u (.clock_i(clock_i),
    .reset_n_i(reset_n_i), .start_i(start_i), .instr_i(instr_i),
    .setup_i(setup_i), .low_flag_i(low_flag_i), .busy_o(busy_o),
    .done_o(done_o), .bad_opts_o(bad_opts_o), .src_ptr_o(src_ptr_o),
    .dst_ptr_o(dst_ptr_o), .req_valid_o(req_valid_o),
    .req_ready_i(req_ready_i), .req_o(req_o), .rd_valid_i(rd_valid_i),
    .rd_data_i(rd_data_i));
  blt_mem_model mem_u (.clock_i(clock_i), .reset_n_i(reset_n_i),
    .stall_i(stall), .req_valid_i(req_valid_o), .req_ready_o(req_ready_i),
    .req_i(req_o), .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Result word before masking
  function automatic logic [15:0] combine(input logic [3:0] op,
      input logic [15:0] s, input logic [15:0] d);
    case (op)
      blt_pkg::OP_AND:  return s & d;
      blt_pkg::OP_XOR:  return s ^ d;
      blt_pkg::OP_COPY: return s;
      default:          return s | d;
    endcase
  endfunction

  // Starts one instruction, may retry start mid-run, waits for done
  task automatic run(input logic [23:0] ins, input bit poke);
    int n;
    c0 = mem_u.cnt;
    stall = $random(seed) % 2 != 0;
    @(negedge clock_i);
    instr_i = ins;
    start_i = 1'b1;
    @(negedge clock_i);
    start_i = 1'b0;
    n = 0;
    while (done_o !== 1'b1 && n < 4000) begin
      @(negedge clock_i);
      n++;
      start_i = poke && n == 3;
      if (poke && n == 3) instr_i = 24'h00_210e;
    end
    start_i = 1'b0;
    check(done_o, 1'b1);
    while (req_valid_o === 1'b1 && n < 4000) begin
      @(negedge clock_i);
      n++;
    end
  endtask

  task automatic bb(input logic [3:0] op, input bit dec, input bit inv,
      input bit odd);
    logic [23:0] s, d, st, ea [$];
    logic [15:0] m, sv, dv, ev [$];
    logic [31:0] x;
    int w, h;
    x = $random(seed);
    w = 2 + (x[27:26] % 3);
    h = 1 + (x[31:30] % 3);
    setup_i.src_base = {12'h004, x[11:1], 1'b0};
    setup_i.dst_base = {12'h008, x[23:13], 1'b0};
    setup_i.shift = 4'h0;
    setup_i.width = 16'(w);
    setup_i.height = 16'(h);
    setup_i.src_warp = odd ? 24'h00_0041 : (x[24] ? 24'h00_0040 : 24'hff_ffc0);
    setup_i.dst_warp = x[24] ? 24'h00_0040 : 24'hff_ffc0;
    setup_i.mask_first = dec ? 16'hffff : 16'($random(seed));
    setup_i.mask_last = dec ? 16'hffff : 16'($random(seed));
    st = dec ? 24'hff_fffe : blt_pkg::WORD_STEP;
    s = setup_i.src_base;
    d = setup_i.dst_base;
    for (int l = 0; l < h; l++) begin
      for (int k = 0; k < w; k++) begin
        sv = inv ? ~mem_u.peek(s) : mem_u.peek(s);
        dv = mem_u.peek(d);
        m = k == 0 ? setup_i.mask_first :
            (k == w - 1 ? setup_i.mask_last : 16'hffff);
        ea.push_back(d);
        ev.push_back((combine(op, sv, dv) & m) | (dv & ~m));
        if (k < w - 1) begin
          s += st;
          d += st;
        end
      end
      s += setup_i.src_warp;
      d += setup_i.dst_warp;
    end
    // Source never overlaps the destination here
    run({8'h00, dec, inv, op, op == blt_pkg::OP_AND ? blt_pkg::I_AND :
        blt_pkg::I_OTHER, 8'h0e}, 1'b0);
    check(bad_opts_o, 1'b0);
    check(dst_ptr_o, d);
    check(mem_u.cnt[2] - c0[2], w * h);
    if (!odd) begin
      check(src_ptr_o, s);
      check(mem_u.cnt[0] - c0[0], w * h);
      foreach (ea[i]) check(mem_u.peek(ea[i]), ev[i]);
    end
  endtask

  task automatic word_or;
    logic [23:0] s, d;
    logic [31:0] e;
    setup_i.shift = 4'($random(seed));
    s = 24'h00_0100;
    d = 24'h00_0200 + 24'({$random(seed)} % 64 * 4);
    setup_i.src_base = s;
    setup_i.dst_base = d;
    e = {mem_u.peek(d + 24'h00_0002), mem_u.peek(d)} |
        (32'(mem_u.peek(s)) << setup_i.shift);
    run(24'h00_210e, 1'b0);
    check({mem_u.peek(d + 24'h00_0002), mem_u.peek(d)}, e);
    check(src_ptr_o, s + 24'h00_0002);
    check(dst_ptr_o, d + 24'h00_0002);
  endtask

  task automatic ext(input bit low, input bit back);
    logic [23:0] d, s;
    int w, h;
    w = 2 + {$random(seed)} % 3;
    h = 1 + {$random(seed)} % 3;
    setup_i.src_base = 24'h00_4000;
    setup_i.dst_base = 24'h00_8100;
    setup_i.width = 16'(2 * w);
    setup_i.height = 16'(h);
    setup_i.h_step = back ? 24'hff_fffe : blt_pkg::WORD_STEP;
    setup_i.src_warp = 24'h00_0040;
    setup_i.dst_warp = 24'h00_0040;
    low_flag_i = low;
    d = 24'h00_8100 + 24'(h) * (24'(w - 1) * setup_i.h_step + 24'h00_0040);
    s = 24'h00_4000 +
        24'(h) * (24'(low ? w - 1 : w) * setup_i.h_step + 24'h00_0040);
    run(24'h00_170e, 1'b1);
    check(mem_u.cnt[0] - c0[0], h * (w + (low ? 0 : 1)));
    check(mem_u.cnt[1] - c0[1], w * h);
    check(mem_u.cnt[2] - c0[2], w * h);
    check(dst_ptr_o, d);
    check(src_ptr_o, s);
  endtask

  initial begin
    #3_000_000;
    mismatches++;
    finish_test();
  end

  initial begin
    repeat (5) @(negedge clock_i);
    reset_n_i = 1'b1;
    for (int p = 0; p < 4; p++) begin
      for (int o = 0; o < 5; o++) begin
        bb(OPS[o], p[0] && o != 3, p[1] && o != 3, 1'b0);
      end
    end
    bb(blt_pkg::OP_COPY, 1'b0, 1'b0, 1'b1);
    c0 = mem_u.cnt;
    run({8'h00, 2'b10, blt_pkg::OP_FAST_OR, blt_pkg::I_OTHER, 8'h0e}, 1'b0);
    check(bad_opts_o, 1'b1);
    check(mem_u.cnt[2] - c0[2], 0);
    repeat (4) word_or();
    for (int p = 0; p < 4; p++) begin
      ext(p[0], p[1]);
    end
    finish_test();
  end
endmodule
